// ==== inc/uarx_pkg.sv ====
// Package with constants and carrier types for the serial receive block.
package uarx_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned FIFO_AW       = 4;
  localparam int unsigned OVS           = 16;
  localparam logic [3:0]  OVS_LAST      = 4'h000F;
  localparam logic [3:0]  OVS_MID       = 4'h0007;
  localparam logic [4:0]  LVL_ONE       = 5'h0_001;
  localparam logic [4:0]  LVL_FOUR      = 5'h0_004;
  localparam logic [4:0]  LVL_EIGHT     = 5'h0_008;
  localparam logic [4:0]  LVL_FOURTEEN  = 5'h0_00E;
  localparam logic [4:0]  LVL_FULL      = 5'h0_010;
  localparam logic [4:0]  LVL_FIFTEEN   = 5'h0_00F;
  localparam logic [15:0] DIV_RESET     = 16'h0001;

  // Register word addresses on the slave bus.
  localparam logic [3:0] ADDR_DATA   = 4'h0000;
  localparam logic [3:0] ADDR_LINE   = 4'h0001;
  localparam logic [3:0] ADDR_STATUS = 4'h0002;
  localparam logic [3:0] ADDR_MODEM  = 4'h0003;
  localparam logic [3:0] ADDR_DIV    = 4'h0004;
  localparam logic [3:0] ADDR_FIFOC  = 4'h0005;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

  // Field positions.
  localparam int unsigned LC_LEN_LO  = 0;
  localparam int unsigned LC_LEN_HI  = 1;
  localparam int unsigned LC_PAR_EN  = 3;
  localparam int unsigned LC_PAR_EVN = 4;
  localparam int unsigned MC_RTS     = 1;
  localparam int unsigned MC_AFE     = 5;
  localparam int unsigned ST_DR      = 0;
  localparam int unsigned ST_OE      = 1;
  localparam int unsigned ST_PE      = 2;
  localparam int unsigned ST_FE      = 3;
  localparam int unsigned ST_BI      = 4;

  typedef enum logic [2:0] {
    UARX_IDLE   = 3'b000,
    UARX_START  = 3'b001,
    UARX_DATA   = 3'b010,
    UARX_PARITY = 3'b011,
    UARX_STOP   = 3'b100
  } uarx_state_t;

  // One received character with its error bits.
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } uarx_char_t;

endpackage

// ==== src/uarx_receiver.sv ====
// Serial receive channel with autoflow control and an Avalon-MM slave.
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - Idle receiver watches line for falling edge.
// - Sample each bit at its centre.
// - Start bit needs low at mid-sample.
// - Start seen within one 16x tick.
// - Two low line bits set data length.
// - Line bits three, four control parity.
// - Data ready set after full character.
// - Non-FIFO read of buffer clears ready.
// - Unread buffer overwritten sets overrun flag.
// - Bad parity sets parity error flag.
// - Missing stop bit sets framing error.
// - FIFO stores character with error bits.
// - Levels 1/4/8: drop RTS at trigger.
// - FIFO still accepts one extra byte.
// - Levels 1/4/8: raise RTS when empty.
// - Level 14: drop RTS at 16th data.
// - Level 14: raise RTS with free space.
// - Transmitter may start only with CTS.
// - CTS changes raise no interrupt under autoflow.
// - Auto-RTS needs enable and RTS bits set; auto-CTS needs enable only.
// - Sample tick is clock over divisor.
module uarx_receiver (
  input  wire logic        clock_i,          // 125 MHz clock
  input  wire logic        reset_n_i,        // Synchronous reset, active low
  input  wire logic [3:0]  avs_address_i,    // Word address
  input  wire logic        avs_read_i,       // Read request
  input  wire logic        avs_write_i,      // Write request
  input  wire logic [31:0] avs_writedata_i,  // Write data
  output logic      [31:0] avs_readdata_o,   // Read data
  output logic             avs_waitrequest_o,// Stall
  input  wire logic        serial_input_pin_i,// Serial input line
  input  wire logic        cts_n_i,          // Clear to send, active low
  output logic             rts_n_o,          // Request to send, active low
  output logic             tx_start_ok_o,    // Transmitter may start a byte
  output logic             modem_irq_o       // CTS change event, one-cycle pulse
);

  logic [7:0]  line_control_setting_reg;
  logic [7:0]  modem_ctl_reg;
  logic [15:0] divisor_reg;
  logic        fifo_en_reg;
  logic [1:0]  trig_sel_reg;
  logic        rx_s1_reg, serial_in_line_reg, rx_prev_reg;
  logic        cts_s1_reg, cts_s2_reg, cts_prev_reg;
  logic [15:0] baud_cnt_reg;
  logic        tick_reg;
  uarx_pkg::uarx_state_t state_reg;
  logic [3:0]  ovs_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  rx_shift_register_reg;
  logic        par_acc_reg;
  logic        char_done_reg;
  uarx_pkg::uarx_char_t char_reg;
  uarx_pkg::uarx_char_t mem [uarx_pkg::FIFO_DEPTH];
  logic [uarx_pkg::FIFO_AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [4:0]  count_reg;
  uarx_pkg::uarx_char_t rx_holding_buffer_reg;
  logic        rx_data_ready_flag_reg;
  logic        overrun_flag_reg;
  logic        parity_err_flag_reg;
  logic        framing_err_flag_reg;
  logic        break_flag_reg;
  logic        ack_reg;

  logic        bus_req, rd_data, rd_status;
  logic        autoflow_enable_bit, flow_full, flow_cts;
  logic [2:0]  len_last;
  logic [4:0]  trig_lvl;
  logic        push, pop;

  assign bus_req   = (avs_read_i | avs_write_i) & ~ack_reg;
  assign rd_data   = avs_read_i & ~ack_reg
                     & (avs_address_i == uarx_pkg::ADDR_DATA);
  assign rd_status = avs_read_i & ~ack_reg
                     & (avs_address_i == uarx_pkg::ADDR_STATUS);
  // Data lengths 5..8 become a last-bit index 4..7.
  assign len_last  = {1'b1,
                      line_control_setting_reg[uarx_pkg::LC_LEN_HI],
                      line_control_setting_reg[uarx_pkg::LC_LEN_LO]};
  assign autoflow_enable_bit = modem_ctl_reg[uarx_pkg::MC_AFE];
  assign flow_full = autoflow_enable_bit
                     & modem_ctl_reg[uarx_pkg::MC_RTS];
  assign flow_cts  = autoflow_enable_bit;
  assign pop  = rd_data & fifo_en_reg & (count_reg != 5'h0_000);
  assign push = char_done_reg & fifo_en_reg
                & (count_reg != uarx_pkg::LVL_FULL);

  always_comb begin
    case (trig_sel_reg)
      2'h0_000: trig_lvl = uarx_pkg::LVL_ONE;
      2'h0_001: trig_lvl = uarx_pkg::LVL_FOUR;
      2'h0_002: trig_lvl = uarx_pkg::LVL_EIGHT;
      default:  trig_lvl = uarx_pkg::LVL_FOURTEEN;
    endcase
  end

  // Bus slave: one wait cycle, then the answer with waitrequest low.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ack_reg           <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_reg           <= bus_req;
      avs_waitrequest_o <= ~bus_req;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      line_control_setting_reg <= 8'h0000;
      modem_ctl_reg            <= 8'h0000;
      divisor_reg              <= uarx_pkg::DIV_RESET;
      fifo_en_reg              <= 1'b0;
      trig_sel_reg             <= 2'h0_000;
    end else if (avs_write_i && !ack_reg) begin
      if (avs_address_i == uarx_pkg::ADDR_LINE) begin
        line_control_setting_reg <= avs_writedata_i[7:0];
      end else if (avs_address_i == uarx_pkg::ADDR_MODEM) begin
        modem_ctl_reg <= avs_writedata_i[7:0];
      end else if (avs_address_i == uarx_pkg::ADDR_DIV) begin
        divisor_reg <= avs_writedata_i[15:0];
      end else if (avs_address_i == uarx_pkg::ADDR_FIFOC) begin
        fifo_en_reg  <= avs_writedata_i[0];
        trig_sel_reg <= avs_writedata_i[7:6];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= uarx_pkg::READ_ZERO;
    end else if (avs_read_i && !ack_reg) begin
      if (avs_address_i == uarx_pkg::ADDR_DATA) begin
        avs_readdata_o <= {24'h00_0000, rx_holding_buffer_reg.data};
      end else if (avs_address_i == uarx_pkg::ADDR_LINE) begin
        avs_readdata_o <= {24'h00_0000, line_control_setting_reg};
      end else if (avs_address_i == uarx_pkg::ADDR_STATUS) begin
        avs_readdata_o <= {27'h000_0000, break_flag_reg,
                           framing_err_flag_reg, parity_err_flag_reg,
                           overrun_flag_reg, rx_data_ready_flag_reg};
      end else if (avs_address_i == uarx_pkg::ADDR_MODEM) begin
        avs_readdata_o <= {24'h00_0000, modem_ctl_reg};
      end else if (avs_address_i == uarx_pkg::ADDR_DIV) begin
        avs_readdata_o <= {16'h0000, divisor_reg};
      end else if (avs_address_i == uarx_pkg::ADDR_FIFOC) begin
        avs_readdata_o <= {24'h00_0000, trig_sel_reg, 1'b0, count_reg};
      end else begin
        avs_readdata_o <= uarx_pkg::READ_ZERO;
      end
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  // CTS stages run through reset, so no false change follows it.
  always_ff @(posedge clock_i) begin
    cts_s1_reg <= cts_n_i;
    cts_s2_reg <= cts_s1_reg;
    if (!reset_n_i) begin
      rx_s1_reg          <= 1'b1;
      serial_in_line_reg <= 1'b1;
    end else begin
      rx_s1_reg          <= serial_input_pin_i;
      serial_in_line_reg <= rx_s1_reg;
    end
  end

  // Sample tick once every divisor clocks; a zero divisor acts as one.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      baud_cnt_reg <= uarx_pkg::DIV_RESET;
      tick_reg     <= 1'b0;
    end else if (baud_cnt_reg <= uarx_pkg::DIV_RESET) begin
      baud_cnt_reg <= divisor_reg;
      tick_reg     <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - uarx_pkg::DIV_RESET;
      tick_reg     <= 1'b0;
    end
  end

  // Receive state machine, line examined on each 16x tick.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_reg             <= uarx_pkg::UARX_IDLE;
      ovs_reg               <= 4'h0000;
      bit_reg               <= 3'h0_000;
      rx_shift_register_reg <= 8'h0000;
      par_acc_reg           <= 1'b0;
      rx_prev_reg           <= 1'b1;
      char_done_reg         <= 1'b0;
      char_reg              <= '0;
    end else begin
      char_done_reg <= 1'b0;
      if (tick_reg) begin
        rx_prev_reg <= serial_in_line_reg;
        case (state_reg)
          uarx_pkg::UARX_IDLE: begin
            if (rx_prev_reg && !serial_in_line_reg) begin
              state_reg <= uarx_pkg::UARX_START;
              ovs_reg   <= 4'h0000;
            end
          end
          uarx_pkg::UARX_START: begin
            ovs_reg <= ovs_reg + 4'h0001;
            if (ovs_reg == uarx_pkg::OVS_MID - 4'h0001) begin
              if (serial_in_line_reg) begin
                state_reg <= uarx_pkg::UARX_IDLE;
              end else begin
                ovs_reg               <= 4'h0000;
                bit_reg               <= 3'h0_000;
                rx_shift_register_reg <= 8'h0000;
                par_acc_reg <=
                  ~line_control_setting_reg[uarx_pkg::LC_PAR_EVN];
                state_reg <= uarx_pkg::UARX_DATA;
              end
            end
          end
          uarx_pkg::UARX_DATA: begin
            ovs_reg <= ovs_reg + 4'h0001;
            if (ovs_reg == uarx_pkg::OVS_LAST) begin
              rx_shift_register_reg[bit_reg] <= serial_in_line_reg;
              par_acc_reg <= par_acc_reg ^ serial_in_line_reg;
              bit_reg     <= bit_reg + 3'h0_001;
              if (bit_reg == len_last) begin
                state_reg <=
                  line_control_setting_reg[uarx_pkg::LC_PAR_EN]
                    ? uarx_pkg::UARX_PARITY : uarx_pkg::UARX_STOP;
              end
            end
          end
          uarx_pkg::UARX_PARITY: begin
            ovs_reg <= ovs_reg + 4'h0001;
            if (ovs_reg == uarx_pkg::OVS_LAST) begin
              par_acc_reg <= par_acc_reg ^ serial_in_line_reg;
              state_reg   <= uarx_pkg::UARX_STOP;
            end
          end
          uarx_pkg::UARX_STOP: begin
            ovs_reg <= ovs_reg + 4'h0001;
            if (ovs_reg == uarx_pkg::OVS_LAST) begin
              char_reg.data <= rx_shift_register_reg;
              char_reg.par  <=
                line_control_setting_reg[uarx_pkg::LC_PAR_EN]
                & par_acc_reg;
              char_reg.frm  <= ~serial_in_line_reg;
              char_reg.brk  <= ~serial_in_line_reg
                               & (rx_shift_register_reg == 8'h0000);
              char_done_reg <= 1'b1;
              state_reg     <= uarx_pkg::UARX_IDLE;
            end
          end
          default: state_reg <= uarx_pkg::UARX_IDLE;
        endcase
      end
    end
  end

  // Receive FIFO; sixteen slots give room for the byte after trigger.
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= char_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !fifo_en_reg) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= 5'h0_000;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {4'h0000, push} - {4'h0000, pop};
    end
  end

  // Holding buffer and status; a new event wins over a read clear.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rx_holding_buffer_reg  <= '0;
      rx_data_ready_flag_reg <= 1'b0;
      overrun_flag_reg       <= 1'b0;
      parity_err_flag_reg    <= 1'b0;
      framing_err_flag_reg   <= 1'b0;
      break_flag_reg         <= 1'b0;
    end else begin
      if (fifo_en_reg) begin
        rx_holding_buffer_reg  <= mem[rd_ptr_reg];
        rx_data_ready_flag_reg <= (count_reg != 5'h0_000) | push;
      end else if (char_done_reg) begin
        rx_holding_buffer_reg  <= char_reg;
        rx_data_ready_flag_reg <= 1'b1;
      end else if (rd_data) begin
        rx_data_ready_flag_reg <= 1'b0;
      end
      if (char_done_reg && (fifo_en_reg
          ? (count_reg == uarx_pkg::LVL_FULL)
          : (rx_data_ready_flag_reg && !rd_data))) begin
        overrun_flag_reg <= 1'b1;
      end else if (rd_status) begin
        overrun_flag_reg <= 1'b0;
      end
      if (char_done_reg && char_reg.par) begin
        parity_err_flag_reg <= 1'b1;
      end else if (rd_status) begin
        parity_err_flag_reg <= 1'b0;
      end
      if (char_done_reg && char_reg.frm) begin
        framing_err_flag_reg <= 1'b1;
      end else if (rd_status) begin
        framing_err_flag_reg <= 1'b0;
      end
      if (char_done_reg && char_reg.brk) begin
        break_flag_reg <= 1'b1;
      end else if (rd_status) begin
        break_flag_reg <= 1'b0;
      end
    end
  end

  // RTS: manual bit unless full autoflow with FIFO mode.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rts_n_o <= 1'b1;
    end else if (!(flow_full && fifo_en_reg)) begin
      rts_n_o <= ~modem_ctl_reg[uarx_pkg::MC_RTS];
    end else if (trig_lvl == uarx_pkg::LVL_FOURTEEN) begin
      if (count_reg == uarx_pkg::LVL_FIFTEEN && (char_done_reg
          || state_reg > uarx_pkg::UARX_START)) begin
        rts_n_o <= 1'b1;
      end else if (count_reg < uarx_pkg::LVL_FULL) begin
        rts_n_o <= 1'b0;
      end
    end else if (count_reg >= trig_lvl) begin
      rts_n_o <= 1'b1;
    end else if (count_reg == 5'h0_000) begin
      rts_n_o <= 1'b0;
    end
  end

  // CTS gating of the transmitter and modem-change event.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cts_prev_reg  <= cts_s2_reg;
      tx_start_ok_o <= 1'b1;
      modem_irq_o   <= 1'b0;
    end else begin
      cts_prev_reg  <= cts_s2_reg;
      tx_start_ok_o <= ~flow_cts | ~cts_s2_reg;
      modem_irq_o   <= (cts_prev_reg != cts_s2_reg) & ~flow_cts;
    end
  end

  a_rts_trigger: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) (flow_full && fifo_en_reg
    && trig_lvl != uarx_pkg::LVL_FOURTEEN && count_reg >= trig_lvl
    && $stable(count_reg) && $stable(trig_sel_reg) && $stable(modem_ctl_reg))
    |=> rts_n_o) else $error("RTS not dropped at trigger");

  a_rts_reassert: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) (flow_full && fifo_en_reg && count_reg == 5'h0_000
    && $stable(modem_ctl_reg) && $stable(fifo_en_reg)) |=> !rts_n_o)
    else $error("RTS not raised on empty FIFO");

  a_cts_gate: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) (flow_cts && cts_s2_reg) |=> !tx_start_ok_o)
    else $error("Transmit allowed without CTS");

  a_no_modem_irq: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) $past(flow_cts) |-> !modem_irq_o)
    else $error("Modem event under autoflow");

  a_false_start: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) (state_reg == uarx_pkg::UARX_START && tick_reg
    && ovs_reg == uarx_pkg::OVS_MID - 4'h0001 && serial_in_line_reg)
    |=> state_reg == uarx_pkg::UARX_IDLE)
    else $error("Noise accepted as start");

  sequence s_char_end;
    state_reg == uarx_pkg::UARX_STOP && tick_reg
    && ovs_reg == uarx_pkg::OVS_LAST;
  endsequence
  a_ready_after: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) s_char_end ##1 char_done_reg |=> rx_data_ready_flag_reg)
    else $error("Data ready not set");

  a_frame_err: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) s_char_end and !serial_in_line_reg |=> ##1
    framing_err_flag_reg) else $error("Framing error missed");

  a_fifo_store: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) push |=> mem[$past(wr_ptr_reg)] == $past(char_reg))
    else $error("FIFO entry lost");

  a_overrun_set: assert property (@(posedge clock_i) disable iff
    (!reset_n_i) (char_done_reg && !fifo_en_reg && rx_data_ready_flag_reg
    && !rd_data) |=> overrun_flag_reg)
    else $error("Overrun not flagged");

endmodule

// ==== test/test_uarx_receiver.sv ====
// Self-checking bench for the serial receive block.
`timescale 1ns/1ps
module test_uarx_receiver;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        line, cts_n, rts_n_o, tx_start_ok_o, modem_irq_o, busy;
  logic        send_s = 1'b0;
  logic        glitch_s = 1'b0;
  logic        hold_s = 1'b0;
  logic [15:0] fr_s = 16'h0;
  logic [31:0] q;
  int          n_errors = 0;
  int          check_count = 0;

  uarx_receiver dut (.clock_i, .reset_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .serial_input_pin_i(line), .cts_n_i(cts_n), .rts_n_o, .tx_start_ok_o,
    .modem_irq_o);
  uarx_remote_model remote (.clock_i, .reset_n_i, .send_i(send_s),
    .frame_i(fr_s[11:0]), .len_i(fr_s[15:12]), .glitch_i(glitch_s),
    .hold_i(hold_s), .rts_n_i(rts_n_o), .line_o(line), .cts_n_o(cts_n),
    .busy_o(busy));

  initial begin
    forever #4 clock_i = ~clock_i;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tmo;
    n_errors++;
    $display("BAD t=%0t wait ran out", $time);
    close_out();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // One bus access; the request stands until waitrequest is seen low.
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_writedata_i <= d;
    do begin
      @(posedge clock_i);
      n++;
      if (n > 40) tmo();
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask

  task automatic rts_is(input logic v);
    @(negedge clock_i);
    chk({31'h0, rts_n_o}, {31'h0, v});
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
      if (n > 4000) tmo();
    end while (busy !== v);
  endtask

  // Frame as {bit count, bits}; start bit first, data LSB first.
  function automatic logic [15:0] mk(input logic [7:0] d,
      input logic [7:0] lc, input logic bp, input logic bs);
    logic [11:0] f;
    int          k;
    f = 12'hFFE;
    k = 1;
    for (int j = 0; j < 5 + int'(lc[1:0]); j++) begin
      f[k] = d[j];
      k++;
    end
    if (lc[3]) begin
      f[k] = ^(d & (8'hFF >> (3 - lc[1:0]))) ^ !lc[4] ^ bp;
      k++;
    end
    f[k] = !bs;
    return {4'(k + 1), f};
  endfunction

  task automatic launch(input logic [7:0] d, input logic [7:0] lc,
                        input logic bp, input logic bs);
    fr_s   <= mk(d, lc, bp, bs);
    send_s <= 1'b1;
  endtask

  task automatic finish_send;
    wait_busy(1'b1);
    @(posedge clock_i);
    send_s <= 1'b0;
    wait_busy(1'b0);
    cyc(4);
  endtask

  task automatic send(input logic [7:0] d, input logic [7:0] lc,
                      input logic bp, input logic bs);
    launch(d, lc, bp, bs);
    finish_send();
  endtask

  task automatic flip(input logic v, output int p);
    @(posedge clock_i);
    hold_s <= v;
    p = 0;
    repeat (20) begin
      @(negedge clock_i);
      p += int'(modem_irq_o === 1'b1);
    end
  endtask

  task automatic t_reset;
    @(negedge clock_i);
    chk({29'h0, rts_n_o, tx_start_ok_o, modem_irq_o}, 32'h6);
    rd(uarx_pkg::ADDR_STATUS, 32'h0);
    rd(4'hF, 32'h0);
    rd(uarx_pkg::ADDR_LINE, 32'h0);
    wr(uarx_pkg::ADDR_DIV, 32'h1);
    rd(uarx_pkg::ADDR_DIV, 32'h1);
    wr(uarx_pkg::ADDR_MODEM, 32'h2);
    rts_is(1'b0);
  endtask

  task automatic t_formats;
    logic [7:0] lc;
    for (int i = 0; i < 4; i++) begin
      lc = 8'(i) | (8'(i & 1) << 3) | (8'(i >> 1) << 4);
      wr(uarx_pkg::ADDR_LINE, 32'(lc));
      send(8'hA5 ^ 8'(i), lc, 1'b0, 1'b0);
      rd(uarx_pkg::ADDR_STATUS, 32'h1);
      rd(uarx_pkg::ADDR_DATA, 32'((8'hA5 ^ 8'(i)) & (8'hFF >> (3 - i))));
      rd(uarx_pkg::ADDR_STATUS, 32'h0);
    end
  endtask

  task automatic t_errors;
    wr(uarx_pkg::ADDR_LINE, 32'h1B);
    send(8'h55, 8'h1B, 1'b1, 1'b0);
    rd(uarx_pkg::ADDR_STATUS, 32'h5);
    rd(uarx_pkg::ADDR_DATA, 32'h55);
    send(8'h55, 8'h1B, 1'b0, 1'b1);
    rd(uarx_pkg::ADDR_STATUS, 32'h9);
    rd(uarx_pkg::ADDR_DATA, 32'h55);
    send(8'h11, 8'h1B, 1'b0, 1'b0);
    send(8'h22, 8'h1B, 1'b0, 1'b0);
    rd(uarx_pkg::ADDR_STATUS, 32'h3);
    rd(uarx_pkg::ADDR_DATA, 32'h22);
    send(8'h00, 8'h1B, 1'b0, 1'b1);
    rd(uarx_pkg::ADDR_STATUS, 32'h19);
    rd(uarx_pkg::ADDR_DATA, 32'h0);
  endtask

  // A spike shorter than half a bit must not start a character.
  task automatic t_glitch;
    @(posedge clock_i);
    glitch_s <= 1'b1;
    @(posedge clock_i);
    glitch_s <= 1'b0;
    cyc(300);
    rd(uarx_pkg::ADDR_STATUS, 32'h0);
    send(8'h3C, 8'h1B, 1'b0, 1'b0);
    rd(uarx_pkg::ADDR_DATA, 32'h3C);
  endtask

  task automatic t_cts;
    int p;
    flip(1'b1, p);
    chk(32'(p), 32'h1);
    chk({31'h0, tx_start_ok_o}, 32'h1);
    flip(1'b0, p);
    wr(uarx_pkg::ADDR_MODEM, 32'h22);
    flip(1'b1, p);
    chk(32'(p), 32'h0);
    chk({31'h0, tx_start_ok_o}, 32'h0);
    flip(1'b0, p);
    chk(32'(p), 32'h0);
    chk({31'h0, tx_start_ok_o}, 32'h1);
  endtask

  task automatic t_levels;
    logic [4:0] lv;
    for (int t = 0; t < 3; t++) begin
      lv = (t == 0) ? uarx_pkg::LVL_ONE :
           (t == 1) ? uarx_pkg::LVL_FOUR : uarx_pkg::LVL_EIGHT;
      wr(uarx_pkg::ADDR_FIFOC, 32'((t << 6) | 1));
      for (int i = 0; i < lv; i++) send(8'h40 + 8'(i), 8'h1B, i == 0, 1'b0);
      rts_is(1'b1);
      launch(8'h7E, 8'h1B, 1'b0, 1'b0);
      cyc(300);
      @(negedge clock_i);
      chk({31'h0, busy}, 32'h0);
      rd(uarx_pkg::ADDR_FIFOC, 32'(t << 6) | 32'(lv));
      rd(uarx_pkg::ADDR_STATUS, 32'h5);
      for (int i = 0; i < lv; i++) rd(uarx_pkg::ADDR_DATA, 32'h40 + 32'(i));
      cyc(3);
      rts_is(1'b0);
      finish_send();
      rd(uarx_pkg::ADDR_DATA, 32'h7E);
    end
  endtask

  task automatic t_fourteen;
    wr(uarx_pkg::ADDR_LINE, 32'h3);
    wr(uarx_pkg::ADDR_FIFOC, 32'hC1);
    for (int i = 0; i < 15; i++) send(8'(i), 8'h03, 1'b0, 1'b0);
    rts_is(1'b0);
    send(8'h0F, 8'h03, 1'b0, 1'b0);
    rts_is(1'b1);
    rd(uarx_pkg::ADDR_FIFOC, 32'hD0);
    rd(uarx_pkg::ADDR_DATA, 32'h0);
    cyc(3);
    rts_is(1'b0);
    rd(uarx_pkg::ADDR_DATA, 32'h1);
    for (int i = 2; i < 16; i++) rd(uarx_pkg::ADDR_DATA, 32'(i));
  endtask

  initial begin
    cyc(4);
    reset_n_i <= 1'b1;
    t_reset();
    t_formats();
    t_errors();
    t_glitch();
    t_cts();
    t_levels();
    t_fourteen();
    close_out();
  end
endmodule

// ==== test/uarx_remote_model.sv ====
// Behavioural model of the remote serial sender with RTS/CTS handshake.
`timescale 1ns/1ps
module uarx_remote_model (
  input  wire logic        clock_i,   // Bench clock
  input  wire logic        reset_n_i, // Synchronous reset, active low
  input  wire logic        send_i,    // Request to send one frame
  input  wire logic [11:0] frame_i,   // Frame bits, start bit at bit 0
  input  wire logic [3:0]  len_i,     // Number of bits in the frame
  input  wire logic        glitch_i,  // Request a short low noise spike
  input  wire logic        hold_i,    // Remote cannot take more data
  input  wire logic        rts_n_i,   // Request to send from the block
  output logic             line_o,    // Serial line towards the block
  output logic             cts_n_o,   // Clear to send towards the block
  output logic             busy_o     // A frame is on the line
);
  logic [11:0] shift_reg;
  logic [3:0]  left_reg;
  logic [3:0]  tick_reg;
  logic [2:0]  glitch_reg;

  // The remote stops the block's next byte by releasing CTS at once.
  assign cts_n_o = hold_i;
  assign busy_o  = (left_reg != 4'h0);
  // Between frames the line rests at its pulled-up idle level.
  assign line_o  = busy_o ? shift_reg[0] : (glitch_reg == 3'h0);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      left_reg   <= 4'h0;
      tick_reg   <= 4'h0;
      glitch_reg <= 3'h0;
      shift_reg  <= 12'hFFF;
    end else if (left_reg == 4'h0) begin
      tick_reg <= 4'h0;
      if (glitch_i) begin
        glitch_reg <= 3'h4;
      end else if (glitch_reg != 3'h0) begin
        glitch_reg <= glitch_reg - 3'h1;
      end
      // A new frame starts only while the block asks for data.
      if (send_i && !rts_n_i) begin
        shift_reg <= frame_i;
        left_reg  <= len_i;
      end
    end else begin
      tick_reg <= tick_reg + 4'h1;
      if (tick_reg == uarx_pkg::OVS_LAST) begin
        shift_reg <= {1'b1, shift_reg[11:1]};
        left_reg  <= left_reg - 4'h1;
      end
    end
  end
endmodule
